// ===== common/cchc_pkg.sv
package cchc_pkg;

  // Register map.
  localparam logic [15:0] CCHC_HW_CTL_OFFSET = 16'h0800;

  // Field positions of the hardware control register.
  localparam int CCHC_POLICY_LSB     = 14;
  localparam int CCHC_PAUSE_BIT      = 12;
  localparam int CCHC_TIMEBASE_BIT   = 11;
  localparam int CCHC_MODE_BIT       = 10;
  localparam int CCHC_RUNNING_BIT    = 9;
  localparam int CCHC_ATTACHED_BIT   = 8;
  localparam int CCHC_CAP_LSB        = 6;
  localparam int CCHC_DETACH_THR_LSB = 3;
  localparam int CCHC_ROLE_BIT       = 2;
  localparam int CCHC_STANDALONE_BIT = 0;

  // Reset values of the software fields before the straps are taken.
  localparam logic [1:0] CCHC_POLICY_RST    = 2'h0;
  localparam logic       CCHC_PAUSE_RST     = 1'b0;
  localparam logic       CCHC_TIMEBASE_RST  = 1'b0;
  localparam logic [2:0] CCHC_DETACH_THR_RST = 3'h0;
  localparam logic [1:0] CCHC_CAP_RST       = 2'h0;

  // Short-circuit discharge policy encodings.
  localparam logic [1:0] CCHC_POLICY_AFTER_REMOVAL = 2'h2;
  localparam logic [1:0] CCHC_POLICY_REMOVAL_OR_TO = 2'h3;

  // Role strap encodings from the configuration-select pins.
  localparam logic [1:0] CCHC_STRAP_UFP = 2'h1;
  localparam logic [1:0] CCHC_STRAP_DFP = 2'h2;

  // Timing: clock period and debounce steps, in nanoseconds.
  localparam int CCHC_CLK_PERIOD_NS = 50;
  localparam int CCHC_STEP_SLOW_NS  = 1600000;
  localparam int CCHC_STEP_FAST_NS  = 100000;
  localparam int CCHC_STEP_SLOW_CYC = CCHC_STEP_SLOW_NS / CCHC_CLK_PERIOD_NS;
  localparam int CCHC_STEP_FAST_CYC = CCHC_STEP_FAST_NS / CCHC_CLK_PERIOD_NS;
  // The discharge wait equals one full threshold scan cycle.
  localparam int CCHC_DISCH_WAIT_NS  = 1600000;
  localparam int CCHC_DISCH_WAIT_CYC = CCHC_DISCH_WAIT_NS / CCHC_CLK_PERIOD_NS;

  typedef struct packed {
    logic [1:0] short_discharge_policy;
    logic       rsv13;
    logic       pause_debounce_on_message;
    logic       match_debounce_timebase;
    logic       standalone_mode;
    logic       line_debouncer_running;
    logic       attached;
    logic [1:0] current_capability;
    logic [2:0] detach_threshold;
    logic       dfp_role;
    logic       rsv1;
    logic       standalone;
  } cchc_ctl_t;

  typedef struct packed {
    logic [7:0] cc1;
    logic [7:0] cc2;
  } cchc_match_t;

endpackage : cchc_pkg

// ===== logic/cchc_hw_control.sv
`timescale 1ns/10ps

// Contract
// - Policy 0x: start VBUS discharge at detach without checking for a short.
// - Policy 10b: start discharge only once the short is gone.
// - Policy 11b: start discharge at short removal or wait expiry, whichever first.
// - Policy field acts only in standalone DFP operation; otherwise ignored.
// - Pause bit set: debouncer halts while a PD message is seen; clear: no pause.
// - Timebase bit picks debounce step: 1.6 ms when 0, 100 us when 1.
// - Mode bit reads 0 in companion mode, 1 in standalone mode.
// - Running bit reads 1 while the line debouncer is enabled, else 0.
// - Attached bit reads 0 when unattached and 1 when attached.
// - Capability field reflects the strapped current capability pins.
// - Writable three-bit field picks the detach threshold for standalone DFP.
// - Role bit: 0 configures UFP, 1 configures DFP.
// - Standalone bit: 0 companion operation, 1 standalone operation.
// - Standalone: logic drives attach, detach, orientation, VCONN (DFP role only) and enables debouncer.
// - Standalone bit resets to 1 when standalone is strapped, else 0.
// - Capability and detach fields reset from pins when present, else zero.
// - Role resets from straps: UFP 0, DFP 1, neither 0.
// - While unattached, match results update only after the debounce interval.
module cchc_hw_control #(
  parameter int SLOW_STEP_CYC  = cchc_pkg::CCHC_STEP_SLOW_CYC,
  parameter int FAST_STEP_CYC  = cchc_pkg::CCHC_STEP_FAST_CYC,
  parameter int DISCH_WAIT_CYC = cchc_pkg::CCHC_DISCH_WAIT_CYC,
  parameter int MATCH_W        = 8
) (
  input  wire logic               clk_sys_in,
  input  wire logic               rst_in,
  input  wire logic [15:0]        reg_addr_in,
  input  wire logic               reg_wr_in,
  input  wire logic               reg_rd_in,
  input  wire logic [15:0]        reg_wdata_in,
  output logic      [15:0]        reg_rdata_out,
  input  wire logic               strap_standalone_in,
  input  wire logic [1:0]         strap_role_in,
  input  wire logic               cap_pins_present_in,
  input  wire logic [1:0]         current_capability_pins_in,
  input  wire logic               debounce_enable_in,
  input  wire logic               pd_msg_detected_in,
  input  wire logic [7:0]         match_debounce_count_in,
  input  wire logic [MATCH_W-1:0] cc1_match_raw_in,
  input  wire logic [MATCH_W-1:0] cc2_match_raw_in,
  input  wire logic               vbus_present_in,
  input  wire logic               vbus_short_in,
  output logic [MATCH_W-1:0]      cc1_match_out,
  output logic [MATCH_W-1:0]      cc2_match_out,
  output logic                    line_debouncer_running_out,
  output logic                    standalone_out,
  output logic                    dfp_role_out,
  output logic                    attached_out,
  output logic                    orientation_out,
  output logic                    vconn_cc1_out,
  output logic                    vconn_cc2_out,
  output logic                    vbus_discharge_out
);

  ////////////////////////////////////////////////////////////////////////////////
  // Software fields and strap capture.

  logic [1:0] policy_q;
  logic       pause_q;
  logic       timebase_q;
  logic [2:0] detach_thr_q;
  logic       role_q;
  logic       standalone_q;
  logic [1:0] cap_q;
  logic       straps_taken_q;
  logic       hit_ctl;
  logic       wr_ctl;
  logic [1:0] cap_strap;
  logic       role_strap;

  assign hit_ctl   = (reg_addr_in == cchc_pkg::CCHC_HW_CTL_OFFSET);
  assign wr_ctl    = reg_wr_in && hit_ctl;
  assign cap_strap = cap_pins_present_in ? current_capability_pins_in : cchc_pkg::CCHC_CAP_RST;

  // Codes 00 and 11 name neither role and fall back to UFP.
  always_comb begin
    unique case (strap_role_in)
      cchc_pkg::CCHC_STRAP_DFP: role_strap = 1'b1;
      cchc_pkg::CCHC_STRAP_UFP: role_strap = 1'b0;
      default:                  role_strap = 1'b0;
    endcase
  end

  // Straps are sampled on the first edge after reset release, never by the reset itself.
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      straps_taken_q <= 1'b0;
    end else begin
      straps_taken_q <= 1'b1;
    end
  end

  // A role write is taken even while the debouncer runs; the block does not refuse it,
  // so software has to wait for the running bit to clear before changing the role.
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      standalone_q <= 1'b0;
      role_q       <= 1'b0;
      detach_thr_q <= cchc_pkg::CCHC_DETACH_THR_RST;
      cap_q        <= cchc_pkg::CCHC_CAP_RST;
    end else if (!straps_taken_q) begin
      standalone_q <= strap_standalone_in;
      role_q       <= role_strap;
      cap_q        <= cap_strap;
      detach_thr_q <= {1'b0, cap_strap};
    end else if (wr_ctl) begin
      standalone_q <= reg_wdata_in[cchc_pkg::CCHC_STANDALONE_BIT];
      role_q       <= reg_wdata_in[cchc_pkg::CCHC_ROLE_BIT];
      detach_thr_q <= reg_wdata_in[cchc_pkg::CCHC_DETACH_THR_LSB +: 3];
    end
  end

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      policy_q   <= cchc_pkg::CCHC_POLICY_RST;
      pause_q    <= cchc_pkg::CCHC_PAUSE_RST;
      timebase_q <= cchc_pkg::CCHC_TIMEBASE_RST;
    end else if (wr_ctl) begin
      policy_q   <= reg_wdata_in[cchc_pkg::CCHC_POLICY_LSB +: 2];
      pause_q    <= reg_wdata_in[cchc_pkg::CCHC_PAUSE_BIT];
      timebase_q <= reg_wdata_in[cchc_pkg::CCHC_TIMEBASE_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Line debouncer timebase and match filtering.

  logic        running;
  logic        paused;
  logic [15:0] step_cnt_q;
  logic [15:0] step_last;
  logic        step_tick;
  logic [7:0]  db_cnt_q;
  logic        attached_q;
  cchc_pkg::cchc_match_t raw;
  cchc_pkg::cchc_match_t stable_q;

  // Standalone operation keeps the debouncer on whatever the companion enable says.
  assign running   = standalone_q || debounce_enable_in;
  assign paused    = pause_q && pd_msg_detected_in;
  assign step_last = timebase_q ? 16'(FAST_STEP_CYC - 1) : 16'(SLOW_STEP_CYC - 1);
  assign step_tick = running && !paused && (step_cnt_q >= step_last);
  assign raw       = '{cc1: cc1_match_raw_in, cc2: cc2_match_raw_in};

  // With the pause bit set, a PD message holds the step count, so the debounce interval stretches by its length.
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      step_cnt_q <= 16'h0000;
    end else if (!running || step_tick) begin
      step_cnt_q <= 16'h0000;
    end else if (!paused) begin
      step_cnt_q <= step_cnt_q + 16'h0001;
    end
  end

  // Attached-state filtering belongs to the PD debounce path, so results pass through here.
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      stable_q <= '0;
      db_cnt_q <= 8'h00;
    end else if (!running) begin
      db_cnt_q <= 8'h00;
    end else if (paused) begin
      db_cnt_q <= db_cnt_q;
    end else if (raw == stable_q) begin
      db_cnt_q <= 8'h00;
    end else if (attached_q) begin
      stable_q <= raw;
      db_cnt_q <= 8'h00;
    end else if (db_cnt_q >= match_debounce_count_in) begin
      stable_q <= raw;
      db_cnt_q <= 8'h00;
    end else if (step_tick) begin
      db_cnt_q <= db_cnt_q + 8'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Standalone attach, detach, orientation and VCONN.

  logic open1;
  logic open2;
  logic orient_q;
  logic attach_ev;
  logic detach_ev;
  logic sa_dfp;

  // A match at the detach threshold means the line is pulled above it, i.e. open.
  assign open1  = stable_q.cc1[detach_thr_q];
  assign open2  = stable_q.cc2[detach_thr_q];
  assign sa_dfp = standalone_q && role_q;

  always_comb begin
    attach_ev = 1'b0;
    detach_ev = 1'b0;
    if (standalone_q && running) begin
      if (role_q) begin
        // A sink pulls exactly one line below the detach threshold.
        attach_ev = !attached_q && (open1 != open2);
        detach_ev = attached_q && (orient_q ? open2 : open1);
      end else begin
        // A source shows VBUS and a pull-up on at least one line.
        attach_ev = !attached_q && vbus_present_in && ((|stable_q.cc1) || (|stable_q.cc2));
        detach_ev = attached_q && !vbus_present_in;
      end
    end
  end

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      attached_q <= 1'b0;
      orient_q   <= 1'b0;
    end else if (!standalone_q) begin
      attached_q <= 1'b0;
    end else if (attach_ev) begin
      attached_q <= 1'b1;
      orient_q   <= role_q ? open1 : (~|stable_q.cc1);
    end else if (detach_ev) begin
      attached_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      vconn_cc1_out <= 1'b0;
      vconn_cc2_out <= 1'b0;
    end else begin
      // VCONN goes to the unused CC line of an attached standalone DFP.
      vconn_cc1_out <= sa_dfp && attached_q && !detach_ev && orient_q;
      vconn_cc2_out <= sa_dfp && attached_q && !detach_ev && !orient_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // VBUS discharge sequencing after a detach.

  typedef enum logic [1:0] {
    CCHC_DS_IDLE  = 2'b00,
    CCHC_DS_WAIT  = 2'b01,
    CCHC_DS_FIRE  = 2'b10
  } cchc_disch_state_t;

  cchc_disch_state_t ds_q;
  logic [31:0]       wait_cnt_q;
  logic              wait_done;
  logic              use_policy;

  // Outside standalone DFP operation the policy is kept for read-back but never consulted.
  assign use_policy = sa_dfp && policy_q[1];
  assign wait_done  = (wait_cnt_q >= 32'(DISCH_WAIT_CYC - 1));

  // The count saturates, so a short that never clears cannot wrap it below the wait.
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      wait_cnt_q <= 32'h0000_0000;
    end else if (ds_q != CCHC_DS_WAIT) begin
      wait_cnt_q <= 32'h0000_0000;
    end else if (!wait_done) begin
      wait_cnt_q <= wait_cnt_q + 32'h0000_0001;
    end
  end

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      ds_q <= CCHC_DS_IDLE;
    end else begin
      unique case (ds_q)
        CCHC_DS_IDLE: begin
          if (detach_ev) begin
            ds_q <= use_policy ? CCHC_DS_WAIT : CCHC_DS_FIRE;
          end
        end
        CCHC_DS_WAIT: begin
          if (!vbus_short_in) begin
            ds_q <= CCHC_DS_FIRE;
          end else if (policy_q == cchc_pkg::CCHC_POLICY_REMOVAL_OR_TO && wait_done) begin
            ds_q <= CCHC_DS_FIRE;
          end
        end
        CCHC_DS_FIRE: begin
          ds_q <= CCHC_DS_IDLE;
        end
        default: begin
          ds_q <= CCHC_DS_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Read-back and outputs.

  cchc_pkg::cchc_ctl_t ctl_view;

  always_comb begin
    ctl_view                           = '0;
    ctl_view.short_discharge_policy    = policy_q;
    ctl_view.pause_debounce_on_message = pause_q;
    ctl_view.match_debounce_timebase   = timebase_q;
    ctl_view.standalone_mode           = standalone_q;
    ctl_view.line_debouncer_running    = running;
    ctl_view.attached                  = attached_q;
    ctl_view.current_capability        = cap_q;
    ctl_view.detach_threshold          = detach_thr_q;
    ctl_view.dfp_role                  = role_q;
    ctl_view.standalone                = standalone_q;
    ctl_view.rsv13                     = 1'b0;
    ctl_view.rsv1                      = 1'b0;
  end

  // Unmapped reads answer zero.
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      reg_rdata_out <= 16'h0000;
    end else if (reg_rd_in && hit_ctl) begin
      reg_rdata_out <= ctl_view;
    end else if (reg_rd_in) begin
      reg_rdata_out <= 16'h0000;
    end
  end

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      vbus_discharge_out <= 1'b0;
    end else begin
      vbus_discharge_out <= (ds_q == CCHC_DS_FIRE);
    end
  end

  assign cc1_match_out              = stable_q.cc1;
  assign cc2_match_out              = stable_q.cc2;
  assign line_debouncer_running_out = running;
  assign standalone_out             = standalone_q;
  assign dfp_role_out               = role_q;
  assign attached_out               = attached_q;
  assign orientation_out            = orient_q;

endmodule : cchc_hw_control

// ===== test/cchc_props.sv
`timescale 1ns/10ps
module cchc_props #(
  parameter int DISCH_WAIT_CYC = 16
) (
  input wire logic        clk_sys_in,
  input wire logic        rst_in,
  input wire logic [15:0] reg_addr_in,
  input wire logic        reg_wr_in,
  input wire logic        reg_rd_in,
  input wire logic [15:0] reg_wdata_in,
  input wire logic [15:0] reg_rdata_out,
  input wire logic        debounce_enable_in,
  input wire logic        vbus_short_in,
  input wire logic [7:0]  cc1_match_out,
  input wire logic        line_debouncer_running_out,
  input wire logic        standalone_out,
  input wire logic        dfp_role_out,
  input wire logic        attached_out,
  input wire logic        vbus_discharge_out
);
  localparam int DW_MAX = DISCH_WAIT_CYC + 4;
  logic [1:0] pol_q;
  wire        hit = reg_addr_in == cchc_pkg::CCHC_HW_CTL_OFFSET;
  ////////////////////////////////////////////////////////////////////////////////
  // The policy field is not visible at the ports, so it is tracked from the writes.
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      pol_q <= 2'h0;
    end else if (reg_wr_in && hit) begin
      pol_q <= reg_wdata_in[15:14];
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (rst_in);
  sequence s_detach;
    standalone_out && $fell(attached_out);
  endsequence
  a_running_is_or: assert property (line_debouncer_running_out == (standalone_out | debounce_enable_in))
    else $error("running bit does not follow its sources");
  a_match_frozen: assert property (!line_debouncer_running_out |=> $stable(cc1_match_out))
    else $error("matches changed while debouncer stopped");
  a_rdata_holds: assert property (!reg_rd_in |=> $stable(reg_rdata_out))
    else $error("read data changed without a read");
  a_reserved_zero: assert property (reg_rd_in |=> !reg_rdata_out[13] && !reg_rdata_out[1])
    else $error("reserved bit read as one");
  a_unmapped_zero: assert property (reg_rd_in && !hit |=> reg_rdata_out == 16'h0000)
    else $error("unmapped read not zero");
  a_status_readback: assert property (reg_rd_in && hit |=>
    reg_rdata_out[10] == $past(standalone_out) && reg_rdata_out[0] == $past(standalone_out)
    && reg_rdata_out[9] == $past(line_debouncer_running_out)
    && reg_rdata_out[8] == $past(attached_out) && reg_rdata_out[2] == $past(dfp_role_out))
    else $error("status bits read back wrong");
  a_companion_detached: assert property (!standalone_out && $past(!standalone_out) |-> !attached_out)
    else $error("attached in companion mode");
  a_plain_discharge: assert property (s_detach ##0 (!dfp_role_out || !pol_q[1]) |=> vbus_discharge_out)
    else $error("discharge not started after detach");
  a_short_blocks: assert property (vbus_discharge_out && dfp_role_out && pol_q == 2'h2 |-> !$past(vbus_short_in, 2))
    else $error("discharge during short");
  a_wait_expiry: assert property (s_detach ##0 (dfp_role_out && pol_q == 2'h3) |-> ##[1:DW_MAX] vbus_discharge_out)
    else $error("discharge wait did not expire");
  a_one_pulse: assert property (vbus_discharge_out |=> !vbus_discharge_out)
    else $error("discharge pulse too long");
endmodule : cchc_props
bind cchc_hw_control cchc_props #(.DISCH_WAIT_CYC(DISCH_WAIT_CYC)) cchc_props_i (
  .clk_sys_in(clk_sys_in), .rst_in(rst_in), .reg_addr_in(reg_addr_in), .reg_wr_in(reg_wr_in),
  .reg_rd_in(reg_rd_in), .reg_wdata_in(reg_wdata_in), .reg_rdata_out(reg_rdata_out),
  .debounce_enable_in(debounce_enable_in), .vbus_short_in(vbus_short_in),
  .cc1_match_out(cc1_match_out), .line_debouncer_running_out(line_debouncer_running_out),
  .standalone_out(standalone_out), .dfp_role_out(dfp_role_out), .attached_out(attached_out),
  .vbus_discharge_out(vbus_discharge_out));

// ===== test/cchc_partner.sv
`timescale 1ns/10ps
module cchc_partner (
  input  wire logic       clk_sys_in,
  input  wire logic       attach_in,
  input  wire logic       flip_in,
  input  wire logic       short_in,
  output logic      [7:0] cc1_raw_out,
  output logic      [7:0] cc2_raw_out,
  output logic            vbus_present_out,
  output logic            vbus_short_out
);
  // An open line sits above every threshold; the sink pull-down drops the used line below bit 0.
  always_ff @(posedge clk_sys_in) begin
    cc1_raw_out      <= (attach_in && !flip_in) ? 8'hfe : 8'hff;
    cc2_raw_out      <= (attach_in && flip_in) ? 8'hfe : 8'hff;
    vbus_present_out <= attach_in;
    vbus_short_out   <= short_in;
  end
endmodule : cchc_partner

// ===== test/cchc_hw_control_tb_top.sv
`timescale 1ns/10ps
module cchc_hw_control_tb_top;
  localparam int DW = 16;
  logic        clk_sys_in, rst_in, wr, rd, s_sa, cap_p, deb_en, pd_msg, att, flip, shrt;
  logic        run, sa, role, attd, ori, vc1, vc2, dis, vb_p, vb_s;
  logic [15:0] addr, wdat, rdat;
  logic [1:0]  s_role, cap;
  logic [7:0]  cnt, r1, r2, m1, m2;
  int          mismatches, n_compared;
  cchc_hw_control #(.SLOW_STEP_CYC(8), .FAST_STEP_CYC(4), .DISCH_WAIT_CYC(DW)) cchc_hw_control_i (
    .clk_sys_in(clk_sys_in), .rst_in(rst_in), .reg_addr_in(addr), .reg_wr_in(wr),
    .reg_rd_in(rd), .reg_wdata_in(wdat), .reg_rdata_out(rdat), .strap_standalone_in(s_sa),
    .strap_role_in(s_role), .cap_pins_present_in(cap_p), .current_capability_pins_in(cap),
    .debounce_enable_in(deb_en), .pd_msg_detected_in(pd_msg), .match_debounce_count_in(cnt),
    .cc1_match_raw_in(r1), .cc2_match_raw_in(r2), .vbus_present_in(vb_p), .vbus_short_in(vb_s),
    .cc1_match_out(m1), .cc2_match_out(m2), .line_debouncer_running_out(run),
    .standalone_out(sa), .dfp_role_out(role), .attached_out(attd), .orientation_out(ori),
    .vconn_cc1_out(vc1), .vconn_cc2_out(vc2), .vbus_discharge_out(dis));
  cchc_partner cchc_partner_i (.clk_sys_in(clk_sys_in), .attach_in(att), .flip_in(flip),
    .short_in(shrt), .cc1_raw_out(r1), .cc2_raw_out(r2), .vbus_present_out(vb_p),
    .vbus_short_out(vb_s));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic finish_test();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : finish_test
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    n_compared++;
    if (got !== exp) begin
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
      mismatches++;
    end
  endtask : chk
  task automatic clks(input int n);
    repeat (n) @(posedge clk_sys_in);
  endtask : clks
  task automatic reg_write(input logic [15:0] a, input logic [15:0] d);
    @(posedge clk_sys_in);
    wr <= 1'b1; addr <= a; wdat <= d;
    @(posedge clk_sys_in);
    wr <= 1'b0;
  endtask : reg_write
  task automatic reg_read(input logic [15:0] a, output logic [15:0] d);
    @(posedge clk_sys_in);
    rd <= 1'b1; addr <= a;
    @(posedge clk_sys_in);
    rd <= 1'b0;
    @(posedge clk_sys_in);
    d = rdat;
  endtask : reg_read
  // Every wait is bounded; running out of patience ends the run as a failure.
  task automatic wait_hi(ref logic sig, input int bound, output int n);
    for (n = 0; n < bound && sig !== 1'b1; n++) clks(1);
    if (n == bound) begin
      chk("wait", 16'h0001, 16'h0000);
      finish_test();
    end
  endtask : wait_hi
  task automatic wait_m1(input logic [7:0] exp, output int n);
    for (n = 0; n < 60 && m1 !== exp; n++) clks(1);
    if (n == 60) begin
      chk("cc1_match", exp, m1);
      finish_test();
    end
  endtask : wait_m1
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset_straps();
    logic [15:0] v;
    logic [6:0]  st[3] = '{7'b1_11_0_10_0, 7'b0_10_1_11_0, 7'b0_01_1_01_0};
    logic [15:0] ex[3] = '{16'h0601, 16'h00dc, 16'h0048};
    for (int i = 0; i < 3; i++) begin
      @(posedge clk_sys_in);
      {s_sa, s_role, cap_p, cap} <= st[i][6:1];
      rst_in <= 1'b1;
      clks(2);
      rst_in <= 1'b0;
      clks(2);
      reg_read(16'h0800, v);
      chk("reset_word", ex[i], v);
    end
    $display("test reset_straps done");
  endtask : t_reset_straps
  task automatic t_reg_access();
    logic [15:0] v;
    logic [15:0] wa[5] = '{16'h0800, 16'h0800, 16'h0802, 16'h0800, 16'h0800};
    logic [15:0] wd[5] = '{16'hfffc, 16'hffff, 16'h0000, 16'hfffc, 16'h0000};
    logic [15:0] ex[5] = '{16'hd87c, 16'hde7d, 16'hde7d, 16'hd87c, 16'h0040};
    for (int i = 0; i < 5; i++) begin
      reg_write(wa[i], wd[i]);
      reg_read(16'h0800, v);
      chk("ctl_word", ex[i], v);
    end
    reg_read(16'h0802, v);
    chk("unmapped", 16'h0000, v);
    $display("test reg_access done");
  endtask : t_reg_access
  task automatic t_debounce();
    int n;
    deb_en <= 1'b1; cnt <= 8'h02; pd_msg <= 1'b1;
    wait_m1(8'hff, n);
    for (int tb = 0; tb < 2; tb++) begin
      reg_write(16'h0800, tb ? 16'h0800 : 16'h0000);
      att <= !att;
      wait_m1(att ? 8'hff : 8'hfe, n);
      chk("deb_time", 16'h0001, 16'(n >= 2 * (tb ? 4 : 8) - 4 && n <= 2 * (tb ? 4 : 8) + 4));
    end
    reg_write(16'h0800, 16'h1800);
    att <= !att;
    clks(30);
    chk("paused", 16'hffff, {m1, m2});
    pd_msg <= 1'b0;
    wait_m1(8'hfe, n);
    deb_en <= 1'b0;
    $display("test debounce done");
  endtask : t_debounce
  task automatic t_discharge();
    logic [15:0] v, w;
    logic [2:0]  ov;
    int          n;
    cnt <= 8'h00;
    for (int p = 0; p < 5; p++) begin
      reg_read(16'h0800, v);
      chk("idle_running", 16'h0000, 16'(v[9]));
      w = (p == 4) ? 16'h8800 : {2'(p), 14'h0804};
      reg_write(16'h0800, w);
      reg_write(16'h0800, w | 16'h0001);
      flip <= p == 1; att <= 1'b1;
      wait_hi(attd, 40, n);
      clks(1);
      ov = {flip, flip && p < 4, !flip && p < 4};
      chk("orient_vconn", {13'h0, ov}, {13'h0, ori, vc1, vc2});
      shrt <= p != 1; att <= 1'b0;
      if (p == 2) begin
        for (n = 0; n < 30 && dis !== 1'b1; n++) clks(1);
        chk("held_by_short", 16'h001e, 16'(n));
        shrt <= 1'b0;
        wait_hi(dis, 8, n);
      end else begin
        wait_hi(dis, 40, n);
        chk("disch_time", 16'h0001, 16'(p == 3 ? n >= DW && n <= DW + 10 : n <= 8));
      end
      shrt <= 1'b0;
      reg_write(16'h0800, w);
    end
    reg_write(16'h0800, 16'h0000);
    $display("test discharge done");
  endtask : t_discharge
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk_sys_in = 1'b0;
    forever #25 clk_sys_in = ~clk_sys_in;
  end
  initial begin
    mismatches = 0; n_compared = 0;
    rst_in = 1'b1; wr = 1'b0; rd = 1'b0; addr = 16'h0000; wdat = 16'h0000;
    s_sa = 1'b0; s_role = 2'h0; cap_p = 1'b0; cap = 2'h0; deb_en = 1'b0; pd_msg = 1'b0;
    cnt = 8'h00; att = 1'b0; flip = 1'b0; shrt = 1'b0;
    clks(2);
    t_reset_straps();
    t_reg_access();
    t_debounce();
    t_discharge();
    finish_test();
  end
endmodule : cchc_hw_control_tb_top
